// ===== rtl/xms_addr.v
`timescale 1ns/1ps
`include "xms_consts.vh"

module xms_addr (
	// Access form and mode
	input wire [1:0] mode,
	input wire form16,
	// Address sources
	input wire [7:0] page,
	input wire [7:0] ptr_hi,
	input wire [7:0] ptr_lo,
	input wire [7:0] idx,
	// Routing
	output reg [15:0] eff_addr,
	output reg onchip,
	output reg drive_hi
);

always @* begin
	eff_addr = form16 ? {ptr_hi, ptr_lo} : {page, idx};
	onchip = (eff_addr[15:`XMS_RAM_AW] == 6'h00);
	drive_hi = form16;
	case (mode)
		`XMS_MODE_INT: begin
			onchip = 1'b1;
			drive_hi = 1'b0;
		end
		`XMS_MODE_SPLIT: begin
			drive_hi = form16;
		end
		// Bank-select split: page byte goes out on the high lines too
		`XMS_MODE_BANK: begin
			drive_hi = 1'b1;
		end
		`XMS_MODE_EXT: begin
			onchip = 1'b0;
			drive_hi = 1'b1;
		end
		default: begin
			onchip = 1'b1;
		end
	endcase
end

endmodule // xms_addr

// ===== rtl/xms_consts.vh
`ifndef XMS_CONSTS_VH
`define XMS_CONSTS_VH

// Register byte offsets on the AHB-Lite bus
`define XMS_OFF_PAGE 8'h00
`define XMS_OFF_CFG 8'h04
`define XMS_OFF_PLO 8'h08
`define XMS_OFF_PHI 8'h0c
`define XMS_OFF_IDX0 8'h10
`define XMS_OFF_IDX1 8'h14
`define XMS_OFF_CMD 8'h18
`define XMS_OFF_STAT 8'h1c
`define XMS_OFF_PTR16 8'h20

// Reset values
`define XMS_RST_BYTE 8'h00
`define XMS_RST_MODE 2'h0
`define XMS_RST_WORD 32'h0000_0000
`define XMS_RST_ADDR 16'h0000
`define XMS_RST_CNT 4'h0

// Mode field of ext_mem_config
`define XMS_MODE_MSB 3
`define XMS_MODE_LSB 2
`define XMS_MODE_INT 2'h0
`define XMS_MODE_SPLIT 2'h1
`define XMS_MODE_BANK 2'h2
`define XMS_MODE_EXT 2'h3

// Command register fields
`define XMS_CMD_FORM 0
`define XMS_CMD_SEL 1
`define XMS_CMD_DIR 2
`define XMS_CMD_DMSB 15
`define XMS_CMD_DLSB 8

// Status register fields
`define XMS_ST_BUSY 0
`define XMS_ST_OFF 1

// On-chip RAM: 1k bytes
`define XMS_RAM_AW 10
`define XMS_RAM_WORDS 1024

// Off-chip strobe length in clock cycles
`define XMS_OFF_CYCLES 4'h4

// AHB-Lite word transfer size
`define XMS_HSIZE_WORD 3'h2

`endif

// ===== rtl/xms_ram.v
`timescale 1ns/1ps
`include "xms_consts.vh"

module xms_ram (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Access port
	input wire en,
	input wire we,
	input wire [`XMS_RAM_AW-1:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);

reg [7:0] mem [0:`XMS_RAM_WORDS-1];

// Storage carries no reset so it maps onto a RAM macro
always @(posedge clk) begin
	if (en && we) begin
		mem[addr] <= wdata;
	end
end

always @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		rdata <= `XMS_RST_BYTE;
	end else if (en) begin
		rdata <= mem[addr];
	end
end

endmodule // xms_ram

// ===== rtl/xms_top.v
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "xms_consts.vh"

module xms_top (
	// Clock and reset
	input wire CLK,
	input wire ARST_N,
	// AHB-Lite slave
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg HREADYOUT,
	output reg HRESP,
	output reg [31:0] HRDATA,
	// Off-chip address bus
	output reg [15:0] A_OUT,
	output reg A_HI_OE,
	output reg A_LO_OE,
	// Off-chip data bus
	output reg [7:0] D_OUT,
	output reg D_OE,
	input wire [7:0] D_IN,
	// Off-chip strobes
	output reg RD_N,
	output reg WR_N,
	// Engine status
	output reg BUSY
);

localparam ST_IDLE = 2'h0;
localparam ST_START = 2'h1;
localparam ST_RAM = 2'h2;
localparam ST_OFF = 2'h3;

// Software-visible registers
reg [7:0] page;
reg [1:0] mode;
reg [7:0] ptr_lo;
reg [7:0] ptr_hi;
reg [7:0] idx0;
reg [7:0] idx1;

// Data phase of the bus
reg [7:0] bus_addr;
reg bus_wr;
reg rd_pend;

// Off-chip data input synchroniser
reg [7:0] din_meta;
reg [7:0] din_sync;

// Move engine
reg [1:0] state;
reg cmd_form;
reg cmd_sel;
reg cmd_dir;
reg [7:0] cmd_data;
reg [7:0] rd_byte;
reg last_off;
reg [15:0] last_addr;
reg [3:0] cnt;

wire [15:0] eff_addr;
wire onchip;
wire drive_hi;
wire [7:0] ram_rdata;
wire [7:0] idx_sel;
wire addr_phase;
wire word_size;
wire cmd_write;
wire ram_go;
reg [31:0] rd_val;

assign addr_phase = HSEL && HTRANS[1] && HREADY;
assign word_size = (HSIZE == `XMS_HSIZE_WORD);
assign cmd_write = bus_wr && (bus_addr == `XMS_OFF_CMD);
assign idx_sel = cmd_sel ? idx1 : idx0;
assign ram_go = (state == ST_START) && onchip;

xms_addr u_addr (
	.mode(mode),
	.form16(cmd_form),
	.page(page),
	.ptr_hi(ptr_hi),
	.ptr_lo(ptr_lo),
	.idx(idx_sel),
	.eff_addr(eff_addr),
	.onchip(onchip),
	.drive_hi(drive_hi)
);

// Low ten bits index the RAM, so in internal mode higher addresses fold back onto it
xms_ram u_ram (
	.clk(CLK),
	.arst_n(ARST_N),
	.en(ram_go),
	.we(cmd_dir),
	.addr(eff_addr[`XMS_RAM_AW-1:0]),
	.wdata(cmd_data),
	.rdata(ram_rdata)
);

// Bus slave: writes take no wait state, reads take one so HRDATA is a flop
always @(posedge CLK or negedge ARST_N) begin
	if (!ARST_N) begin
		bus_addr <= `XMS_RST_BYTE;
		bus_wr <= 1'b0;
		rd_pend <= 1'b0;
		HREADYOUT <= 1'b1;
		HRESP <= 1'b0;
		HRDATA <= `XMS_RST_WORD;
	end else begin
		bus_wr <= 1'b0;
		HRESP <= 1'b0;
		if (rd_pend) begin
			HRDATA <= rd_val;
			HREADYOUT <= 1'b1;
			rd_pend <= 1'b0;
		end
		if (addr_phase) begin
			bus_addr <= HADDR[7:0];
			// Only whole-word writes land; narrower ones are dropped
			bus_wr <= HWRITE && word_size;
			if (!HWRITE) begin
				rd_pend <= 1'b1;
				HREADYOUT <= 1'b0;
			end
		end
	end
end

// Register writes in the data phase
always @(posedge CLK or negedge ARST_N) begin
	if (!ARST_N) begin
		page <= `XMS_RST_BYTE;
		mode <= `XMS_RST_MODE;
		ptr_lo <= `XMS_RST_BYTE;
		ptr_hi <= `XMS_RST_BYTE;
		idx0 <= `XMS_RST_BYTE;
		idx1 <= `XMS_RST_BYTE;
	end else if (bus_wr) begin
		case (bus_addr)
			`XMS_OFF_PAGE: begin
				page <= HWDATA[7:0];
			end
			`XMS_OFF_CFG: begin
				mode <= HWDATA[`XMS_MODE_MSB:`XMS_MODE_LSB];
			end
			`XMS_OFF_PLO: begin
				ptr_lo <= HWDATA[7:0];
			end
			`XMS_OFF_PHI: begin
				ptr_hi <= HWDATA[7:0];
			end
			`XMS_OFF_PTR16: begin
				ptr_lo <= HWDATA[7:0];
				ptr_hi <= HWDATA[15:8];
			end
			`XMS_OFF_IDX0: begin
				idx0 <= HWDATA[7:0];
			end
			`XMS_OFF_IDX1: begin
				idx1 <= HWDATA[7:0];
			end
			default: begin
				page <= page;
			end
		endcase
	end
end

// Read mux; unmapped offsets and reserved bits read zero
always @* begin
	rd_val = `XMS_RST_WORD;
	case (bus_addr)
		`XMS_OFF_PAGE: begin
			rd_val[7:0] = page;
		end
		`XMS_OFF_CFG: begin
			rd_val[`XMS_MODE_MSB:`XMS_MODE_LSB] = mode;
		end
		`XMS_OFF_PLO: begin
			rd_val[7:0] = ptr_lo;
		end
		`XMS_OFF_PHI: begin
			rd_val[7:0] = ptr_hi;
		end
		`XMS_OFF_PTR16: begin
			rd_val[15:0] = {ptr_hi, ptr_lo};
		end
		`XMS_OFF_IDX0: begin
			rd_val[7:0] = idx0;
		end
		`XMS_OFF_IDX1: begin
			rd_val[7:0] = idx1;
		end
		`XMS_OFF_CMD: begin
			rd_val[15:0] = {cmd_data, 5'h00, cmd_dir, cmd_sel, cmd_form};
		end
		`XMS_OFF_STAT: begin
			rd_val[31:16] = last_addr;
			rd_val[15:8] = rd_byte;
			rd_val[`XMS_ST_OFF] = last_off;
			rd_val[`XMS_ST_BUSY] = BUSY;
		end
		default: begin
			rd_val = `XMS_RST_WORD;
		end
	endcase
end

// Pin data passes two flops before the engine samples it
always @(posedge CLK or negedge ARST_N) begin
	if (!ARST_N) begin
		din_meta <= `XMS_RST_BYTE;
		din_sync <= `XMS_RST_BYTE;
	end else begin
		din_meta <= D_IN;
		din_sync <= din_meta;
	end
end

// Move engine; a command written while busy is ignored
always @(posedge CLK or negedge ARST_N) begin
	if (!ARST_N) begin
		state <= ST_IDLE;
		BUSY <= 1'b0;
		cmd_form <= 1'b0;
		cmd_sel <= 1'b0;
		cmd_dir <= 1'b0;
		cmd_data <= `XMS_RST_BYTE;
		rd_byte <= `XMS_RST_BYTE;
		last_off <= 1'b0;
		last_addr <= `XMS_RST_ADDR;
		cnt <= `XMS_RST_CNT;
		A_OUT <= `XMS_RST_ADDR;
		A_HI_OE <= 1'b0;
		A_LO_OE <= 1'b0;
		D_OUT <= `XMS_RST_BYTE;
		D_OE <= 1'b0;
		RD_N <= 1'b1;
		WR_N <= 1'b1;
	end else begin
		case (state)
			ST_IDLE: begin
				if (cmd_write) begin
					cmd_form <= HWDATA[`XMS_CMD_FORM];
					cmd_sel <= HWDATA[`XMS_CMD_SEL];
					cmd_dir <= HWDATA[`XMS_CMD_DIR];
					cmd_data <= HWDATA[`XMS_CMD_DMSB:`XMS_CMD_DLSB];
					BUSY <= 1'b1;
					state <= ST_START;
				end
			end
			ST_START: begin
				last_addr <= eff_addr;
				last_off <= !onchip;
				if (onchip) begin
					state <= ST_RAM;
				end else begin
					// High lines float when not driven; port latches hold them
					A_OUT <= {drive_hi ? eff_addr[15:8] : 8'h00, eff_addr[7:0]};
					A_HI_OE <= drive_hi;
					A_LO_OE <= 1'b1;
					D_OUT <= cmd_data;
					D_OE <= cmd_dir;
					RD_N <= cmd_dir;
					WR_N <= !cmd_dir;
					cnt <= `XMS_OFF_CYCLES;
					state <= ST_OFF;
				end
			end
			ST_RAM: begin
				if (!cmd_dir) begin
					rd_byte <= ram_rdata;
				end
				BUSY <= 1'b0;
				state <= ST_IDLE;
			end
			ST_OFF: begin
				if (cnt == 4'h1) begin
					if (!cmd_dir) begin
						rd_byte <= din_sync;
					end
					RD_N <= 1'b1;
					WR_N <= 1'b1;
					D_OE <= 1'b0;
					A_HI_OE <= 1'b0;
					A_LO_OE <= 1'b0;
					BUSY <= 1'b0;
					state <= ST_IDLE;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

endmodule // xms_top

// ===== test/xdata_address_mode_select_test.sv
`timescale 1ns/1ps
module xdata_address_mode_select_test;
	logic CLK = 0;
	logic ARST_N = 0;
	logic HSEL = 0;
	logic HWRITE = 0;
	logic [31:0] HADDR = 0;
	logic [31:0] HWDATA = 0;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2;
	logic [2:0] sz = 3'h2;
	logic [31:0] HRDATA;
	logic [31:0] q;
	logic [15:0] A_OUT;
	logic [7:0] D_OUT;
	logic [7:0] D_IN;
	logic HREADYOUT, HRESP, A_HI_OE, A_LO_OE, D_OE, RD_N, WR_N, BUSY;
	int err_count = 0;
	int n_compared = 0;
	always #20 CLK = ~CLK;
	xms_top dut_u (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .A_OUT(A_OUT),
		.A_HI_OE(A_HI_OE), .A_LO_OE(A_LO_OE), .D_OUT(D_OUT), .D_OE(D_OE), .D_IN(D_IN),
		.RD_N(RD_N), .WR_N(WR_N), .BUSY(BUSY));
	xms_mem #(.LAG(1)) mem_u (.CLK(CLK), .A_OUT(A_OUT), .A_HI_OE(A_HI_OE), .RD_N(RD_N),
		.WR_N(WR_N), .D_OUT(D_OUT), .D_OE(D_OE), .D_IN(D_IN));
	task report_and_stop;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task hang;
		err_count++;
		$display("ERROR %0t wait ran out", $time);
		report_and_stop;
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 20);
		if (HREADYOUT !== 1'b1)
			hang;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		HSEL <= 1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		HSIZE <= sz;
		rdy;
		HSEL <= 0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rdy;
		q = HRDATA;
	endtask
	// Commands are dropped while busy, so each move polls status to the end
	task mv(input logic [15:0] cmd);
		int n;
		bus(1, 8'h18, {16'h0, cmd});
		n = 0;
		do begin
			bus(0, 8'h1c, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 20);
		if (q[0] !== 1'b0)
			hang;
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		ARST_N <= 1;
		bus(0, 8'h04, 0);
		chk(q, 0);
		bus(1, 8'h20, 32'h1234);
		bus(0, 8'h08, 0);
		chk(q, 32'h34);
		bus(0, 8'h0c, 0);
		chk(q, 32'h12);
		bus(1, 8'h00, 32'h04);
		bus(1, 8'h10, 0);
		mv(16'h5a04);
		chk(q[31:16], 16'h0400);
		chk(BUSY, 0);
		bus(1, 8'h20, 32'h1000);
		mv(16'h0001);
		chk(q[15:0], 16'h5a00);
		chk(q[31:16], 16'h1000);
		bus(1, 8'h04, 32'h4);
		bus(1, 8'h00, 32'h12);
		bus(1, 8'h14, 32'h56);
		mv(16'h0002);
		chk(q, 32'h1256f302);
		chk(A_OUT[7:0], 8'h56);
		// A byte-sized write must leave the page register alone
		sz = 3'h0;
		bus(1, 8'h00, 32'h77);
		sz = 3'h2;
		bus(0, 8'h00, 0);
		chk(q, 32'h12);
		bus(1, 8'h20, 32'h0800);
		mv(16'h3c05);
		chk(A_OUT, 16'h0800);
		bus(1, 8'h20, 32'h03ff);
		mv(16'h0001);
		chk(q[1], 0);
		bus(1, 8'h04, 32'h8);
		bus(1, 8'h20, 32'h0800);
		mv(16'h0001);
		chk(q[15:0], 16'h3c02);
		bus(1, 8'h04, 32'hc);
		bus(0, 8'h04, 0);
		chk(q[3:2], 2'h3);
		bus(1, 8'h20, 32'h0010);
		mv(16'h0001);
		chk(q[15:0], 16'hb502);
		report_and_stop;
	end
endmodule // xdata_address_mode_select_test

// ===== test/xms_mem.sv
`timescale 1ns/1ps
module xms_mem #(parameter int LAG = 0) (
	// Clock
	input wire logic CLK,
	// Address and strobes
	input wire logic [15:0] A_OUT,
	input wire logic A_HI_OE,
	input wire logic RD_N,
	input wire logic WR_N,
	// Data
	input wire logic [7:0] D_OUT,
	input wire logic D_OE,
	output logic [7:0] D_IN
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	int cnt = 0;
	// Undriven high lines read as the port latches, assumed cleared
	wire [15:0] addr = {A_HI_OE ? A_OUT[15:8] : 8'h00, A_OUT[7:0]};
	wire ok = !RD_N && cnt >= LAG;
	// High byte folds into the pattern so a wrongly driven A[15:8] reads a different byte
	initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
	always @(posedge CLK) begin
		cnt <= RD_N ? 0 : cnt + 1;
		if (!WR_N && D_OE)
			mem[addr] <= D_OUT;
		if (ok)
			last <= mem[addr];
	end
	// Released bus shows the inverse of the last byte, never a stale copy
	assign D_IN = ok ? mem[addr] : ~last;
endmodule // xms_mem

// ===== test/xms_props.sv
`timescale 1ns/1ps
module xms_props (
	// Clock and reset
	input wire CLK,
	input wire ARST_N,
	// Bus
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	input wire HREADYOUT,
	input wire HRESP,
	// Off-chip side
	input wire [15:0] A_OUT,
	input wire A_HI_OE,
	input wire A_LO_OE,
	input wire D_OE,
	input wire RD_N,
	input wire WR_N
);
	reg wr_cfg;
	reg [1:0] mode;
	wire req = HSEL && HTRANS[1] && HREADY;
	// Shadow of the mode field, so routing checks know which mode is in force
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_cfg <= 1'b0;
			mode <= 2'h0;
		end else begin
			wr_cfg <= req && HWRITE && HADDR[7:0] == 8'h04;
			if (wr_cfg)
				mode <= HWDATA[3:2];
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	sequence rd_wait_s;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	sequence rd_hold_s;
		(!RD_N && A_LO_OE)[*4] ##1 (RD_N && !A_LO_OE);
	endsequence
	sequence wr_hold_s;
		(!WR_N && D_OE && A_LO_OE)[*4] ##1 (WR_N && !D_OE);
	endsequence
	rd_wait_a: assert property (req && !HWRITE |=> rd_wait_s)
		else $error("read wait wrong");
	wr_nowait_a: assert property (req && HWRITE |=> HREADYOUT && !HRESP)
		else $error("write stalled");
	rd_len_a: assert property ($fell(RD_N) |-> rd_hold_s)
		else $error("read strobe wrong");
	wr_len_a: assert property ($fell(WR_N) |-> wr_hold_s)
		else $error("write strobe wrong");
	int_only_a: assert property (mode == 2'h0 |-> RD_N && WR_N && !A_LO_OE)
		else $error("off-chip access in internal mode");
	split_hi_a: assert property (mode == 2'h1 && A_HI_OE |-> A_OUT[15:10] != 6'h0)
		else $error("low address sent off-chip");
	split_lo_a: assert property (mode == 2'h1 && A_LO_OE && !A_HI_OE |-> A_OUT[15:8] == 8'h00)
		else $error("undriven high byte not clear");
	full_bus_a: assert property (mode[1] && A_LO_OE |-> A_HI_OE)
		else $error("high lines not driven");
endmodule // xms_props

bind xms_top xms_props xms_props_u (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .A_OUT(A_OUT), .A_HI_OE(A_HI_OE), .A_LO_OE(A_LO_OE), .D_OE(D_OE),
	.RD_N(RD_N), .WR_N(WR_N));
